// ==== inc/dcss_pkg.sv ====
// Constants, types and register map of the drive command source select block.
// Assumes one 125 MHz clock and a byte-addressed Avalon-MM register bus.
// Behaviour
// - Mode 0 V/F, 1 sensorless vector
// - Direction setting only under keypad run source
// - Reverse inhibited plus keypad reverse setting: show lockout
// - Run source keypad, terminals, communication
// - Function-12 input swaps main/alternative run source
// - Mode 0: function 0 forward, 1 reverse
// - Mode 1: function 0 runs, 1 reverses
// - Mode 2: inputs 1-3 fixed, functions ignored
// - Start pulse accepted only while stop closed
// - Frequency sources 0-6 decoded
// - Combine 0: function-13 input picks alternative
// - Combine 1: main plus alternative frequency
// - Communication frequency 0-599.00 Hz, readable back
// - Save setting picks retained frequency
// - Keypad initial frequency: current, zero, set point
// - Zero limit and command: no run, stop
// - Command above lower limit: ramp from zero
// - Otherwise ramp starts at lower limit
// - Two accel/decel time sets, 0.1-3600.0 s
package dcss_pkg;

  // ==========================================
  // Widths and ranges
  localparam int FREQ_W = 16; // 0.01 Hz units
  localparam logic [15:0] FREQ_MAX = 16'he9fc; // 599.00 Hz
  localparam logic [15:0] LOWER_MAX = 16'he9fb; // 598.99 Hz
  localparam logic [15:0] UPPER_MIN = 16'h0001; // 0.01 Hz
  localparam logic [15:0] TIME_MIN = 16'h0001; // 0.1 s
  localparam logic [15:0] TIME_MAX = 16'h8ca0; // 3600.0 s
  localparam int NUM_IN = 5; // Terminal inputs
  localparam int FUNC_W = 4; // Function code width per input
  localparam logic [3:0] FN_FWD = 4'h0;
  localparam logic [3:0] FN_REV = 4'h1;
  localparam logic [3:0] FN_RUN_ALT = 4'hc;
  localparam logic [3:0] FN_FREQ_ALT = 4'hd;

  // ==========================================
  // Register word indices (byte address is four times the index)
  localparam logic [5:0] R_CTRL = 6'h00, R_DIR = 6'h01, R_RSRC_M = 6'h02;
  localparam logic [5:0] R_RSRC_A = 6'h03, R_TMODE = 6'h04, R_FSRC_M = 6'h05;
  localparam logic [5:0] R_FSRC_A = 6'h06, R_FCOMB = 6'h07, R_COMMF = 6'h08;
  localparam logic [5:0] R_SAVE = 6'h09, R_INITS = 6'h0a, R_INITF = 6'h0b;
  localparam logic [5:0] R_UPPER = 6'h0c, R_LOWER = 6'h0d, R_ACC1 = 6'h0e;
  localparam logic [5:0] R_DEC1 = 6'h0f, R_ACC2 = 6'h10, R_DEC2 = 6'h11;
  localparam logic [5:0] R_REVINH = 6'h12, R_TSET = 6'h13, R_MFI = 6'h14;
  localparam logic [5:0] R_CMD = 6'h15, R_KPF = 6'h16, R_STAT = 6'h17;
  localparam logic [5:0] R_FOUT = 6'h18, R_KEEP = 6'h19;

  // ==========================================
  // Reset values
  localparam logic [15:0] UPPER_RST = 16'he9fc;
  localparam logic [15:0] TIME_RST = 16'h0064; // 10.0 s
  localparam logic [19:0] MFI_RST = 20'h43210; // Inputs 1..5 -> 0,1,2,3,4

  // ==========================================
  // Enumerations
  typedef enum logic [1:0] {RS_KEYPAD = 2'h0, RS_TERM = 2'h1, RS_COMM = 2'h2}
    dcss_run_src_t;
  typedef enum logic [1:0] {TM_FWD_REV = 2'h0, TM_RUN_DIR = 2'h1, TM_THREE = 2'h2}
    dcss_term_mode_t;
  typedef enum logic [2:0] {FS_KEY_UPDN = 3'h0, FS_POT = 3'h1, FS_VOLT = 3'h2,
    FS_CURR = 3'h3, FS_EXT_UPDN = 3'h4, FS_COMM = 3'h5, FS_LOOP = 3'h6}
    dcss_freq_src_t;
  typedef enum logic {TW_STOPPED = 1'b0, TW_RUNNING = 1'b1} dcss_tw_state_t;

  // Outputs toward the power stage
  typedef struct packed {
    logic run;
    logic reverse;
    logic sensorless_vector_control;
    logic reverse_lockout_indication;
    logic stop_indication;
    logic [15:0] freq_target;
    logic [15:0] ramp_start;
    logic [15:0] accel_time;
    logic [15:0] decel_time;
  } dcss_drive_t;

  // Frequency source values, all in 0.01 Hz
  typedef struct packed {
    logic [15:0] keypad_pot;
    logic [15:0] voltage_analog_input;
    logic [15:0] current_analog_input;
    logic [15:0] ext_updown;
    logic [15:0] loop_output;
  } dcss_fsrc_t;

endpackage

// ==== rtl/dcss_select.sv ====
// Run and frequency command selection with its parameter registers.
// Assumes terminal pins are asynchronous, analog values are already in
// the mclk domain, and software uses Avalon-MM with waitrequest.
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module dcss_select (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Terminal pins, first to fifth multifunction input
  input wire logic [4:0] term_in,
  // Frequency source values
  input wire dcss_pkg::dcss_fsrc_t fsrc,
  // Drive commands
  output dcss_pkg::dcss_drive_t drive,
  output logic [15:0] retained_freq
);

  // ==========================================
  // Parameter registers
  logic ctrl_reg; // Control mode
  logic dir_reg; // Keypad direction
  logic [1:0] rsrc_m_reg, rsrc_a_reg; // Run sources
  logic [1:0] tmode_reg; // Terminal mode
  logic [2:0] fsrc_m_reg, fsrc_a_reg; // Frequency sources
  logic fcomb_reg; // Frequency combination
  logic [15:0] commf_reg; // Communication frequency
  logic save_reg; // Power-down save select
  logic [1:0] inits_reg; // Initial frequency mode
  logic [15:0] initf_reg, upper_reg, lower_reg; // Set points and limits
  logic [15:0] acc1_reg, dec1_reg, acc2_reg, dec2_reg; // Ramp times
  logic revinh_reg; // Reverse inhibit
  logic tset_reg; // Second time set select
  logic [19:0] mfi_reg; // Input function codes
  logic [15:0] kpf_reg; // Keypad frequency
  logic kp_run_reg; // Keypad run latch
  logic comm_run_reg, comm_rev_reg; // Communication run command
  logic ack_reg; // Bus answer phase

  // Bus decode helpers
  logic [5:0] widx;
  logic wr_take;
  logic [31:0] rd_next;
  assign widx = address[7:2];
  assign wr_take = write & ack_reg;

  // Saturate a write to a range
  function automatic logic [15:0] sat(input logic [31:0] v, input logic [15:0] lo,
    input logic [15:0] hi);
    logic [15:0] r;
    r = (v > {16'h0000, hi}) ? hi : v[15:0];
    if (r < lo) begin
      r = lo;
    end
    return r;
  endfunction

  // ==========================================
  // Bus handshake
  // One wait cycle per access; the answer stands on the second edge
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
    end
  end
  assign waitrequest = (read | write) & ~ack_reg;

  // ==========================================
  // Terminal synchroniser, three stages
  logic [4:0] s1_reg, s2_reg, s3_reg, term_reg, term_prev_reg;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s1_reg <= 5'h00;
      s2_reg <= 5'h00;
      s3_reg <= 5'h00;
      term_reg <= 5'h00;
      term_prev_reg <= 5'h00;
    end else begin
      s1_reg <= term_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Bit changes count only once stages two and three agree
      for (int i = 0; i < 5; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          term_reg[i] <= s3_reg[i];
        end
      end
      term_prev_reg <= term_reg;
    end
  end

  // ==========================================
  // Function code decode over the five inputs
  logic fn_fwd, fn_rev, fn_ralt, fn_falt, three_wire;
  assign three_wire = (tmode_reg == dcss_pkg::TM_THREE);
  always_comb begin
    fn_fwd = 1'b0;
    fn_rev = 1'b0;
    fn_ralt = 1'b0;
    fn_falt = 1'b0;
    // Three-wire mode ignores every function assignment
    if (!three_wire) begin
      for (int i = 0; i < 5; i++) begin
        if (term_reg[i]) begin
          if (mfi_reg[i*4 +: 4] == dcss_pkg::FN_FWD) fn_fwd = 1'b1;
          if (mfi_reg[i*4 +: 4] == dcss_pkg::FN_REV) fn_rev = 1'b1;
          if (mfi_reg[i*4 +: 4] == dcss_pkg::FN_RUN_ALT) fn_ralt = 1'b1;
          if (mfi_reg[i*4 +: 4] == dcss_pkg::FN_FREQ_ALT) fn_falt = 1'b1;
        end
      end
    end
  end

  // Active run source
  logic [1:0] run_src;
  assign run_src = fn_ralt ? rsrc_a_reg : rsrc_m_reg;

  // ==========================================
  // Three-wire start/stop latch
  // Stop contact is normally closed, so a broken wire also stops
  dcss_pkg::dcss_tw_state_t tw_reg;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tw_reg <= dcss_pkg::TW_STOPPED;
    end else begin
      case (tw_reg)
        dcss_pkg::TW_STOPPED: begin
          // Start edge taken only with the stop contact closed
          if (three_wire && term_reg[0] && !term_prev_reg[0] && term_reg[1]) begin
            tw_reg <= dcss_pkg::TW_RUNNING;
          end
        end
        default: begin
          if (!three_wire || !term_reg[1]) begin
            tw_reg <= dcss_pkg::TW_STOPPED;
          end
        end
      endcase
    end
  end

  // ==========================================
  // Run request and direction per source
  logic run_req, rev_req, lockout;
  always_comb begin
    run_req = 1'b0;
    rev_req = 1'b0;
    lockout = 1'b0;
    case (run_src)
      dcss_pkg::RS_KEYPAD: begin
        // Direction setting counts only here
        run_req = kp_run_reg;
        rev_req = dir_reg;
        if (revinh_reg && dir_reg) begin
          lockout = 1'b1;
          run_req = 1'b0;
          rev_req = 1'b0;
        end
      end
      dcss_pkg::RS_TERM: begin
        case (tmode_reg)
          dcss_pkg::TM_FWD_REV: begin
            // Both switches on is treated as stop
            run_req = fn_fwd ^ fn_rev;
            rev_req = fn_rev & ~fn_fwd;
          end
          dcss_pkg::TM_RUN_DIR: begin
            run_req = fn_fwd;
            rev_req = fn_rev;
          end
          dcss_pkg::TM_THREE: begin
            run_req = (tw_reg == dcss_pkg::TW_RUNNING);
            rev_req = term_reg[2];
          end
          default: begin
            run_req = 1'b0;
          end
        endcase
      end
      dcss_pkg::RS_COMM: begin
        run_req = comm_run_reg;
        rev_req = comm_rev_reg;
      end
      default: begin
        run_req = 1'b0;
      end
    endcase
  end

  // ==========================================
  // Frequency source selection
  function automatic logic [15:0] fpick(input logic [2:0] code, input logic [15:0] kp,
    input logic [15:0] cm, input dcss_pkg::dcss_fsrc_t s);
    logic [15:0] f;
    case (code)
      dcss_pkg::FS_KEY_UPDN: f = kp;
      dcss_pkg::FS_POT: f = s.keypad_pot;
      dcss_pkg::FS_VOLT: f = s.voltage_analog_input;
      dcss_pkg::FS_CURR: f = s.current_analog_input;
      dcss_pkg::FS_EXT_UPDN: f = s.ext_updown;
      dcss_pkg::FS_COMM: f = cm;
      dcss_pkg::FS_LOOP: f = s.loop_output;
      default: f = 16'h0000;
    endcase
    return f;
  endfunction

  logic [15:0] f_main, f_alt, f_sel, f_cmd;
  logic [16:0] f_sum;
  assign f_main = fpick(fsrc_m_reg, kpf_reg, commf_reg, fsrc);
  assign f_alt = fpick(fsrc_a_reg, kpf_reg, commf_reg, fsrc);
  assign f_sum = {1'b0, f_main} + {1'b0, f_alt};
  always_comb begin
    if (fcomb_reg) begin
      // Sum saturates before the limit clamp
      f_sel = f_sum[16] ? 16'hffff : f_sum[15:0];
    end else begin
      f_sel = fn_falt ? f_alt : f_main;
    end
    // Clamp between lower and upper limits
    if (f_sel > upper_reg) begin
      f_cmd = upper_reg;
    end else if (f_sel < lower_reg) begin
      f_cmd = lower_reg;
    end else begin
      f_cmd = f_sel;
    end
  end

  // ==========================================
  // Drive output registers
  logic no_run;
  assign no_run = (lower_reg == 16'h0000) && (f_sel == 16'h0000);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      drive <= '0;
    end else begin
      drive.sensorless_vector_control <= ctrl_reg;
      drive.reverse_lockout_indication <= lockout;
      drive.run <= run_req & ~no_run;
      drive.stop_indication <= run_req & no_run;
      drive.reverse <= rev_req;
      drive.freq_target <= f_cmd;
      // Ramp start point is the lower limit unless the command is above it, then zero
      drive.ramp_start <= (f_sel > lower_reg) ? 16'h0000 : lower_reg;
      drive.accel_time <= tset_reg ? acc2_reg : acc1_reg;
      drive.decel_time <= tset_reg ? dec2_reg : dec1_reg;
    end
  end

  // Frequency kept over power down
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      retained_freq <= 16'h0000;
    end else begin
      retained_freq <= save_reg ? commf_reg : kpf_reg;
    end
  end

  // ==========================================
  // Keypad run latch and keypad frequency
  // Start loads the initial frequency; software writes win otherwise
  logic kp_start;
  assign kp_start = wr_take && widx == dcss_pkg::R_CMD && writedata[0];
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      kp_run_reg <= 1'b0;
      kpf_reg <= 16'h0000;
    end else begin
      if (kp_start) begin
        kp_run_reg <= 1'b1;
      end else if (wr_take && widx == dcss_pkg::R_CMD && writedata[1]) begin
        kp_run_reg <= 1'b0;
      end
      if (kp_start && !kp_run_reg && run_src == dcss_pkg::RS_KEYPAD) begin
        case (inits_reg)
          2'h1: kpf_reg <= 16'h0000;
          2'h2: kpf_reg <= initf_reg;
          default: kpf_reg <= kpf_reg;
        endcase
      end else if (wr_take && widx == dcss_pkg::R_KPF) begin
        kpf_reg <= sat(writedata, 16'h0000, dcss_pkg::FREQ_MAX);
      end
    end
  end

  // ==========================================
  // Register writes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl_reg <= 1'b0;
      dir_reg <= 1'b0;
      rsrc_m_reg <= 2'h0;
      rsrc_a_reg <= 2'h0;
      tmode_reg <= 2'h0;
      fsrc_m_reg <= 3'h0;
      fsrc_a_reg <= 3'h0;
      fcomb_reg <= 1'b0;
      commf_reg <= 16'h0000;
      save_reg <= 1'b0;
      inits_reg <= 2'h0;
      initf_reg <= 16'h0000;
      upper_reg <= dcss_pkg::UPPER_RST;
      lower_reg <= 16'h0000;
      acc1_reg <= dcss_pkg::TIME_RST;
      dec1_reg <= dcss_pkg::TIME_RST;
      acc2_reg <= dcss_pkg::TIME_RST;
      dec2_reg <= dcss_pkg::TIME_RST;
      revinh_reg <= 1'b0;
      tset_reg <= 1'b0;
      mfi_reg <= dcss_pkg::MFI_RST;
      comm_run_reg <= 1'b0;
      comm_rev_reg <= 1'b0;
    end else if (wr_take) begin
      // Out-of-range codes are refused, values saturate
      if (widx == dcss_pkg::R_CTRL) begin
        ctrl_reg <= writedata[0];
      end else if (widx == dcss_pkg::R_DIR) begin
        dir_reg <= writedata[0];
      end else if (widx == dcss_pkg::R_RSRC_M && writedata[1:0] != 2'h3) begin
        rsrc_m_reg <= writedata[1:0];
      end else if (widx == dcss_pkg::R_RSRC_A && writedata[1:0] != 2'h3) begin
        rsrc_a_reg <= writedata[1:0];
      end else if (widx == dcss_pkg::R_TMODE && writedata[1:0] != 2'h3) begin
        tmode_reg <= writedata[1:0];
      end else if (widx == dcss_pkg::R_FSRC_M && writedata[2:0] != 3'h7) begin
        fsrc_m_reg <= writedata[2:0];
      end else if (widx == dcss_pkg::R_FSRC_A && writedata[2:0] != 3'h7) begin
        fsrc_a_reg <= writedata[2:0];
      end else if (widx == dcss_pkg::R_FCOMB) begin
        fcomb_reg <= writedata[0];
      end else if (widx == dcss_pkg::R_COMMF) begin
        commf_reg <= sat(writedata, 16'h0000, dcss_pkg::FREQ_MAX);
      end else if (widx == dcss_pkg::R_SAVE) begin
        save_reg <= writedata[0];
      end else if (widx == dcss_pkg::R_INITS && writedata[1:0] != 2'h3) begin
        inits_reg <= writedata[1:0];
      end else if (widx == dcss_pkg::R_INITF) begin
        initf_reg <= sat(writedata, 16'h0000, dcss_pkg::FREQ_MAX);
      end else if (widx == dcss_pkg::R_UPPER) begin
        upper_reg <= sat(writedata, dcss_pkg::UPPER_MIN, dcss_pkg::FREQ_MAX);
      end else if (widx == dcss_pkg::R_LOWER) begin
        lower_reg <= sat(writedata, 16'h0000, dcss_pkg::LOWER_MAX);
      end else if (widx == dcss_pkg::R_ACC1) begin
        acc1_reg <= sat(writedata, dcss_pkg::TIME_MIN, dcss_pkg::TIME_MAX);
      end else if (widx == dcss_pkg::R_DEC1) begin
        dec1_reg <= sat(writedata, dcss_pkg::TIME_MIN, dcss_pkg::TIME_MAX);
      end else if (widx == dcss_pkg::R_ACC2) begin
        acc2_reg <= sat(writedata, dcss_pkg::TIME_MIN, dcss_pkg::TIME_MAX);
      end else if (widx == dcss_pkg::R_DEC2) begin
        dec2_reg <= sat(writedata, dcss_pkg::TIME_MIN, dcss_pkg::TIME_MAX);
      end else if (widx == dcss_pkg::R_REVINH) begin
        revinh_reg <= writedata[0];
      end else if (widx == dcss_pkg::R_TSET) begin
        tset_reg <= writedata[0];
      end else if (widx == dcss_pkg::R_MFI) begin
        mfi_reg <= writedata[19:0];
      end else if (widx == dcss_pkg::R_CMD) begin
        comm_run_reg <= writedata[2];
        comm_rev_reg <= writedata[3];
      end
    end
  end

  // ==========================================
  // Read mux, sampled in the wait cycle
  always_comb begin
    rd_next = 32'h0000_0000;
    if (widx == dcss_pkg::R_CTRL) begin
      rd_next[0] = ctrl_reg;
    end else if (widx == dcss_pkg::R_DIR) begin
      rd_next[0] = dir_reg;
    end else if (widx == dcss_pkg::R_RSRC_M) begin
      rd_next[1:0] = rsrc_m_reg;
    end else if (widx == dcss_pkg::R_RSRC_A) begin
      rd_next[1:0] = rsrc_a_reg;
    end else if (widx == dcss_pkg::R_TMODE) begin
      rd_next[1:0] = tmode_reg;
    end else if (widx == dcss_pkg::R_FSRC_M) begin
      rd_next[2:0] = fsrc_m_reg;
    end else if (widx == dcss_pkg::R_FSRC_A) begin
      rd_next[2:0] = fsrc_a_reg;
    end else if (widx == dcss_pkg::R_FCOMB) begin
      rd_next[0] = fcomb_reg;
    end else if (widx == dcss_pkg::R_COMMF) begin
      rd_next[15:0] = commf_reg;
    end else if (widx == dcss_pkg::R_SAVE) begin
      rd_next[0] = save_reg;
    end else if (widx == dcss_pkg::R_INITS) begin
      rd_next[1:0] = inits_reg;
    end else if (widx == dcss_pkg::R_INITF) begin
      rd_next[15:0] = initf_reg;
    end else if (widx == dcss_pkg::R_UPPER) begin
      rd_next[15:0] = upper_reg;
    end else if (widx == dcss_pkg::R_LOWER) begin
      rd_next[15:0] = lower_reg;
    end else if (widx == dcss_pkg::R_ACC1) begin
      rd_next[15:0] = acc1_reg;
    end else if (widx == dcss_pkg::R_DEC1) begin
      rd_next[15:0] = dec1_reg;
    end else if (widx == dcss_pkg::R_ACC2) begin
      rd_next[15:0] = acc2_reg;
    end else if (widx == dcss_pkg::R_DEC2) begin
      rd_next[15:0] = dec2_reg;
    end else if (widx == dcss_pkg::R_REVINH) begin
      rd_next[0] = revinh_reg;
    end else if (widx == dcss_pkg::R_TSET) begin
      rd_next[0] = tset_reg;
    end else if (widx == dcss_pkg::R_MFI) begin
      rd_next[19:0] = mfi_reg;
    end else if (widx == dcss_pkg::R_CMD) begin
      rd_next[3:0] = {comm_rev_reg, comm_run_reg, 1'b0, kp_run_reg};
    end else if (widx == dcss_pkg::R_KPF) begin
      rd_next[15:0] = kpf_reg;
    end else if (widx == dcss_pkg::R_STAT) begin
      // Live state of the selection logic
      rd_next[11:0] = {term_reg, run_src, tw_reg, drive.stop_indication,
        drive.reverse_lockout_indication, drive.reverse, drive.run};
    end else if (widx == dcss_pkg::R_FOUT) begin
      rd_next[31:0] = {drive.ramp_start, drive.freq_target};
    end else if (widx == dcss_pkg::R_KEEP) begin
      rd_next[15:0] = retained_freq;
    end
  end

  // Read data registered so it stands when waitrequest drops
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack_reg) begin
      readdata <= rd_next;
    end
  end

endmodule

// ==== bench/dcss_select_props.sv ====
// Checker for the command select block: bus wait and drive relations.
// Assumes it is bound to dcss_select and sees only its ports.
`timescale 1ns/1ps
module dcss_select_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Register bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // Drive side
  input wire dcss_pkg::dcss_drive_t drive,
  input wire logic [15:0] retained_freq
);
  // ==========================================
  // Assertions, one clock domain
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_WAIT_FIRST: assert property ((read || write) && !$past(read || write) |-> waitrequest)
    else $error("no wait cycle on new access");
  AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("wait longer than one cycle");
  AST_IDLE: assert property (!(read || write) |-> !waitrequest)
    else $error("wait while idle");
  AST_LOCKOUT: assert property (drive.reverse_lockout_indication |-> !drive.run)
    else $error("run during lockout");
  AST_STOP: assert property (drive.stop_indication |-> !drive.run)
    else $error("run with stop shown");
  AST_RAMP_LOWER: assert property (drive.ramp_start != 16'h0000 |->
    drive.freq_target == drive.ramp_start)
    else $error("ramp start not at lower limit");
  AST_TARGET_CAP: assert property (drive.freq_target <= 16'he9fc)
    else $error("target above ceiling");
  // Times only checked once reset values have reached the outputs
  AST_TIMES: assert property ($past(resetn, 2) |->
    drive.accel_time inside {[16'h0001:16'h8ca0]} &&
    drive.decel_time inside {[16'h0001:16'h8ca0]})
    else $error("ramp time out of range");
  AST_MODE_SRC: assert property ($changed(drive.sensorless_vector_control) |->
    $past(write, 2) && $past(address[7:2], 2) == 6'h00)
    else $error("mode changed without a write");
  AST_RETAIN: assert property (retained_freq <= 16'he9fc)
    else $error("retained frequency too high");
  // Main scenarios reached
  COV_RUN: cover property (drive.run && drive.reverse);
  COV_LOCK: cover property (drive.reverse_lockout_indication);
  COV_STOP: cover property (drive.stop_indication);
  COV_RAMP: cover property (drive.ramp_start != 16'h0000);
endmodule
bind dcss_select dcss_select_props u_props (.mclk(mclk), .resetn(resetn), .address(address),
  .read(read), .write(write), .waitrequest(waitrequest), .drive(drive),
  .retained_freq(retained_freq));

// ==== bench/dcss_operator.sv ====
// Operator model: maintained switches plus a momentary start button.
// Assumes the bench raises press for ten cycles per start.
`timescale 1ns/1ps
module dcss_operator (
  // Clock
  input wire logic mclk,
  // Requests from the bench
  input wire logic [4:0] sw,
  input wire logic press,
  // Terminal pins
  output logic [4:0] term_in
);
  logic [3:0] hold_reg = 4'h0; // Button time left
  // Held 12 cycles so the pin filter cannot miss a short press
  always_ff @(posedge mclk) begin
    hold_reg <= press ? 4'hc : (hold_reg != 4'h0 ? hold_reg - 4'h1 : 4'h0);
  end
  // Maintained levels; stop contact is sw[1], high when closed
  assign term_in = sw | {4'h0, hold_reg != 4'h0};
endmodule

// ==== bench/drive_command_source_select_bench.sv ====
// Self-checking bench for dcss_select.
// Assumes the operator model drives the pins; bench owns bus and analog values.
`timescale 1ns/1ps
module drive_command_source_select_bench;
  // ==========================================
  // Signals
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [4:0] sw = 5'h00;
  logic press = 1'b0;
  logic [4:0] term_in;
  dcss_pkg::dcss_fsrc_t fsrc = {16'h0064, 16'h012c, 16'h0190, 16'h00c8, 16'h00fa};
  dcss_pkg::dcss_drive_t drive;
  logic [15:0] retained_freq;
  int fail_count = 0;
  int n_compared = 0;
  typedef struct {logic [5:0] i; logic [31:0] w; logic [31:0] r;} dcss_row_t;
  // Write value beside its readback; refused codes keep the old value
  dcss_row_t rows [9] = '{'{6'h00, 32'h1, 32'h1}, '{6'h08, 32'hffff, 32'he9fc},
    '{6'h0d, 32'hffff, 32'he9fb}, '{6'h0c, 32'h0, 32'h1}, '{6'h0e, 32'h0, 32'h1},
    '{6'h11, 32'hffff, 32'h8ca0}, '{6'h02, 32'h3, 32'h0}, '{6'h05, 32'h7, 32'h0},
    '{6'h3f, 32'h5, 32'h0}};
  logic [15:0] fexp [7] = '{16'h0, 16'h64, 16'h12c, 16'h190, 16'hc8, 16'he9fc, 16'hfa};
  always #4 mclk = ~mclk;
  dcss_select DUT (.mclk(mclk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .term_in(term_in), .fsrc(fsrc), .drive(drive), .retained_freq(retained_freq));
  dcss_operator u_op (.mclk(mclk), .sw(sw), .press(press), .term_in(term_in));
  // ==========================================
  // Tasks
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // Held until waitrequest is sampled low at a rising edge; bounded wait
  task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    address <= {i, 2'b00};
    writedata <= d;
    write <= w;
    read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      fail_count++;
      close_out();
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask
  task automatic rdc(input string s, input logic [5:0] i, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, i, 32'h0, q);
    chk(s, e, q);
  endtask
  task automatic pins(input logic [4:0] s);
    sw <= s;
    repeat (10) @(posedge mclk);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    rdc("upper", 6'h0c, 32'he9fc);
    rdc("acc1", 6'h0e, 32'h64);
    foreach (rows[k]) begin
      wr(rows[k].i, rows[k].w);
      rdc("row", rows[k].i, rows[k].r);
    end
    chk("svc", 32'h1, {31'h0, drive.sensorless_vector_control});
    chk("tset0", 32'h00010064, {drive.accel_time, drive.decel_time});
    wr(6'h13, 32'h1);
    chk("tset1", 32'h00648ca0, {drive.accel_time, drive.decel_time});
    wr(6'h00, 32'h0);
    wr(6'h0c, 32'he9fc);
    wr(6'h0d, 32'h0);
    wr(6'h16, 32'h3e8);
    wr(6'h15, 32'h1);
    chk("run", 32'h1, {31'h0, drive.run});
    chk("ramp0", 32'h0, {16'h0, drive.ramp_start});
    wr(6'h01, 32'h1);
    chk("rev", 32'h1, {31'h0, drive.reverse});
    wr(6'h12, 32'h1);
    chk("lock", 32'h3, {30'h0, drive.reverse_lockout_indication, !drive.run});
    wr(6'h12, 32'h0);
    wr(6'h01, 32'h0);
    wr(6'h0d, 32'h7d0);
    chk("ramplo", 32'h7d0, {16'h0, drive.ramp_start});
    wr(6'h0d, 32'h0);
    wr(6'h0a, 32'h2);
    wr(6'h0b, 32'h1f4);
    wr(6'h15, 32'h2);
    wr(6'h15, 32'h1);
    rdc("init2", 6'h16, 32'h1f4);
    wr(6'h0a, 32'h1);
    wr(6'h15, 32'h2);
    wr(6'h15, 32'h1);
    rdc("init1", 6'h16, 32'h0);
    chk("stop", 32'h1, {31'h0, drive.stop_indication & !drive.run});
    wr(6'h15, 32'h2);
    foreach (fexp[k]) begin
      wr(6'h05, 32'(k));
      chk("fsrc", {16'h0, fexp[k]}, {16'h0, drive.freq_target});
    end
    chk("save0", 32'h0, {16'h0, retained_freq});
    wr(6'h09, 32'h1);
    chk("save1", 32'he9fc, {16'h0, retained_freq});
    wr(6'h05, 32'h2);
    wr(6'h06, 32'h3);
    wr(6'h14, 32'hd0);
    pins(5'h02);
    chk("alt", 32'h190, {16'h0, drive.freq_target});
    wr(6'h07, 32'h1);
    chk("sum", 32'h2bc, {16'h0, drive.freq_target});
    wr(6'h07, 32'h0);
    wr(6'h14, 32'hc10);
    wr(6'h02, 32'h1);
    pins(5'h01);
    chk("m0fwd", 32'h2, {30'h0, drive.run, drive.reverse});
    pins(5'h05);
    chk("altsrc", 32'h0, {31'h0, drive.run});
    pins(5'h02);
    chk("m0rev", 32'h3, {30'h0, drive.run, drive.reverse});
    wr(6'h04, 32'h1);
    pins(5'h03);
    chk("m1rev", 32'h3, {30'h0, drive.run, drive.reverse});
    wr(6'h04, 32'h2);
    pins(5'h00);
    press <= 1'b1;
    pins(5'h00);
    press <= 1'b0;
    pins(5'h00);
    chk("m2open", 32'h0, {31'h0, drive.run});
    pins(5'h02);
    press <= 1'b1;
    pins(5'h02);
    press <= 1'b0;
    pins(5'h02);
    chk("m2run", 32'h1, {31'h0, drive.run});
    pins(5'h00);
    chk("m2stop", 32'h0, {31'h0, drive.run});
    wr(6'h02, 32'h2);
    wr(6'h15, 32'hc);
    chk("comm", 32'h3, {30'h0, drive.run, drive.reverse});
    close_out();
  end
endmodule
